// ### hdl/dbp_fifo.sv
// small valid/ready fifo with registered read data
`timescale 1ns/100ps
module dbp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic ov_q, ov_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  //////////////////////////////////////////////////////////////////////
  // pointers; output register refills whenever empty or being drained
  always_comb begin
    push = in_valid && rdy_q;
    pop = (cnt_q != '0) && (!ov_q || out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // ready registered from the next count, so it leaves on a flop
    rdy_d = (cnt_d != DEPTH[AW:0]);
    out_d = pop ? mem_q[rd_q] : out_q;
    ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      ov_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      ov_q <= ov_d;
      rdy_q <= rdy_d;
    end
  end

  // storage carries no reset, so it maps onto plain ram
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = rdy_q;
  assign out_data = out_q;
  assign out_valid = ov_q;
endmodule : dbp_fifo

// ### hdl/dbp_pipe.sv
// dual bank byte pipeline register, top level
// Functional notes
// - two 8-stage pipelines or one 16-stage line, chosen each cycle by operation code
// - code 00 pushes input into first bank, its tail feeds second bank
// - code 01 pushes input into second bank only; first bank unchanged
// - code 10 pushes input into first bank only; second bank unchanged
// - code 11 freezes all sixteen stages
// - select msb 0 shows first bank stage given by lower three bits
// - select msb 1 shows second bank stage given by lower three bits
// - reading by select is independent of loading by operation code
`timescale 1ns/100ps
module dbp_pipe #(
  parameter int unsigned DEPTH = dbp_pkg::BANK_DEPTH,
  parameter int unsigned FDEPTH = dbp_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [dbp_pkg::DATA_W-1:0] byte_input,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] operation_code,
  input wire logic [dbp_pkg::SEL_W-1:0] stage_select,
  input wire logic output_enable_n,
  output logic [dbp_pkg::DATA_W-1:0] byte_output,
  output logic byte_output_oe
);
  localparam int unsigned W = dbp_pkg::DATA_W;
  logic [W-1:0] first_q [DEPTH];
  logic [W-1:0] first_d [DEPTH];
  logic [W-1:0] second_q [DEPTH];
  logic [W-1:0] second_d [DEPTH];
  logic [W-1:0] y_q, y_d;
  logic oe_q, oe_d;
  logic [W-1:0] f_data;
  logic f_valid, f_ready;
  logic [1:0] op_q;
  logic shift_first, shift_second, chain, step;

  //////////////////////////////////////////////////////////////////////
  // input fifo: each byte plus its operation waits here
  dbp_fifo #(.WIDTH(W + 2), .DEPTH(FDEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data({operation_code, byte_input}),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data({op_q, f_data}),
    .out_valid(f_valid),
    .out_ready(f_ready)
  );

  // freeze words are consumed without moving any stage
  always_comb begin
    f_ready = 1'b1;
    step = f_valid;
    shift_first = step && (op_q == dbp_pkg::OP_PUSH_BOTH || op_q == dbp_pkg::OP_PUSH_FIRST);
    shift_second = step && (op_q == dbp_pkg::OP_PUSH_BOTH || op_q == dbp_pkg::OP_PUSH_SECOND);
    chain = (op_q == dbp_pkg::OP_PUSH_BOTH);
  end

  //////////////////////////////////////////////////////////////////////
  // next stage values, one generate slice per stage
  for (genvar i = 0; i < DEPTH; i++) begin : g_stage
    always_comb begin
      first_d[i] = first_q[i];
      second_d[i] = second_q[i];
      if (shift_first) begin
        first_d[i] = (i == 0) ? f_data : first_q[(i == 0) ? 0 : i - 1];
      end
      if (shift_second) begin
        if (i == 0) begin
          second_d[i] = chain ? first_q[DEPTH-1] : f_data;
        end else begin
          second_d[i] = second_q[(i == 0) ? 0 : i - 1];
        end
      end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        first_q[i] <= dbp_pkg::STAGE_RESET;
        second_q[i] <= dbp_pkg::STAGE_RESET;
      end else begin
        first_q[i] <= first_d[i];
        second_q[i] <= second_d[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output mux, registered; select works whatever the operation
  always_comb begin
    if (stage_select[dbp_pkg::SEL_BANK_BIT]) begin
      y_d = second_d[stage_select[2:0]];
    end else begin
      y_d = first_d[stage_select[2:0]];
    end
    oe_d = !output_enable_n;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      y_q <= dbp_pkg::STAGE_RESET;
      oe_q <= 1'b0;
    end else begin
      y_q <= y_d;
      oe_q <= oe_d;
    end
  end

  assign byte_output = y_q;
  assign byte_output_oe = oe_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_step_both;
    f_valid && op_q == dbp_pkg::OP_PUSH_BOTH;
  endsequence

  a_chain_head: assert property (@(posedge clk_sys) disable iff (rst)
    s_step_both |=> second_q[0] == $past(first_q[DEPTH-1]))
    else $error("chained head wrong");
  a_first_load: assert property (@(posedge clk_sys) disable iff (rst)
    s_step_both |=> first_q[0] == $past(f_data))
    else $error("first bank load wrong");
  a_second_only: assert property (@(posedge clk_sys) disable iff (rst)
    f_valid && op_q == dbp_pkg::OP_PUSH_SECOND |=>
    second_q[0] == $past(f_data) && $stable(first_q[3]))
    else $error("second push wrong");
  a_first_only: assert property (@(posedge clk_sys) disable iff (rst)
    f_valid && op_q == dbp_pkg::OP_PUSH_FIRST |=>
    first_q[1] == $past(first_q[0]) && $stable(second_q[5]))
    else $error("first push wrong");
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !f_valid || op_q == dbp_pkg::OP_FREEZE |=>
    $stable(first_q[7]) && $stable(second_q[0]))
    else $error("freeze moved a stage");
  a_sel_first: assert property (@(posedge clk_sys) disable iff (rst)
    !stage_select[3] |=> byte_output == first_q[$past(stage_select[2:0])])
    else $error("first bank read wrong");
  a_sel_second: assert property (@(posedge clk_sys) disable iff (rst)
    stage_select[3] |=> byte_output == second_q[$past(stage_select[2:0])])
    else $error("second bank read wrong");
  a_read_shift: assert property (@(posedge clk_sys) disable iff (rst)
    (s_step_both and (stage_select == 4'h0)) |=> byte_output == $past(f_data))
    else $error("read during load wrong");
  a_out_enable: assert property (@(posedge clk_sys) disable iff (rst)
    output_enable_n |=> !byte_output_oe)
    else $error("output driven while disabled");
  a_chain_16: assert property (@(posedge clk_sys) disable iff (rst)
    s_step_both ##1 s_step_both |=> second_q[1] == $past(first_q[DEPTH-1], 2))
    else $error("sixteen stage chain broken");
endmodule : dbp_pipe

// ### inc/dbp_pkg.sv
// constants for the dual bank pipeline register
package dbp_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_DEPTH = 8;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  // operation codes
  localparam logic [1:0] OP_PUSH_BOTH = 2'h0;
  localparam logic [1:0] OP_PUSH_SECOND = 2'h1;
  localparam logic [1:0] OP_PUSH_FIRST = 2'h2;
  localparam logic [1:0] OP_FREEZE = 2'h3;
  // stage_select bank bit position and stage reset value
  localparam int unsigned SEL_BANK_BIT = 3;
  localparam logic [DATA_W-1:0] STAGE_RESET = 8'h00;
endpackage : dbp_pkg

// ### testbench/dbp_host.sv
// host datapath model driving data, operation and select
`timescale 1ns/100ps
module dbp_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] mode,
  output logic [dbp_pkg::DATA_W-1:0] byte_input,
  output logic in_valid,
  output logic [1:0] operation_code,
  output logic [dbp_pkg::SEL_W-1:0] stage_select,
  output logic output_enable_n
);
  // quiet bus at time zero
  initial begin
    byte_input = 8'h00;
    in_valid = 1'b0;
    operation_code = dbp_pkg::OP_FREEZE;
    stage_select = 4'h0;
    output_enable_n = 1'b1;
  end
  // one offer per edge; runs in the caller's thread so its seed applies
  task automatic step();
    @(posedge clk_sys);
    byte_input <= 8'($urandom);
    in_valid <= !rst && ($urandom % 4 != 0); // no offer while reset holds
    if (mode == 2'h1) begin
      operation_code <= dbp_pkg::OP_PUSH_BOTH; // long chained runs fill all 16
    end else if (mode == 2'h2 && $urandom % 2 == 1) begin
      operation_code <= dbp_pkg::OP_FREEZE;
    end else begin
      operation_code <= 2'($urandom);
    end
    stage_select <= 4'($urandom);
    output_enable_n <= ($urandom % 4 == 0);
  endtask : step
endmodule : dbp_host

// ### testbench/test_dbp_pipe.sv
// self-checking bench with behavioural stage model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_dbp_pipe;
  logic clk_sys, rst, in_valid, in_ready, output_enable_n, byte_output_oe;
  logic [1:0] mode, operation_code;
  logic [7:0] byte_input, byte_output, exp_bus, exp_sel, t;
  logic exp_oe;
  logic [3:0] stage_select;
  logic [7:0] first_m [8];
  logic [7:0] second_m [8];
  int q[$];
  int fail_count = 0;
  int tests_run = 0;
  // three-state pin as seen by the shared bus
  wire [7:0] y_bus = byte_output_oe ? byte_output : 8'hzz;
  dbp_pipe u_dbp_pipe (.clk_sys(clk_sys), .rst(rst), .byte_input(byte_input),
    .in_valid(in_valid), .in_ready(in_ready), .operation_code(operation_code),
    .stage_select(stage_select), .output_enable_n(output_enable_n),
    .byte_output(byte_output), .byte_output_oe(byte_output_oe));
  dbp_host u_dbp_host (.clk_sys(clk_sys), .rst(rst), .mode(mode), .byte_input(byte_input),
    .in_valid(in_valid), .operation_code(operation_code), .stage_select(stage_select),
    .output_enable_n(output_enable_n));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // model: a taken op reaches the stages two edges later
  always @(posedge clk_sys or posedge rst) begin
    int e;
    if (rst) begin
      foreach (first_m[i]) first_m[i] = 8'h00;
      foreach (second_m[i]) second_m[i] = 8'h00;
      q = {};
      exp_sel = 8'h00;
      exp_oe = 1'b0;
      exp_bus = 8'hzz;
    end else begin
      q.push_back((in_valid && in_ready) ? int'(operation_code) * 256 + int'(byte_input) : 768);
      if (q.size() > 2) begin
        e = q.pop_front();
        t = first_m[7];
        if (e / 256 == 0 || e / 256 == 2) begin
          for (int i = 7; i > 0; i--) first_m[i] = first_m[i-1];
          first_m[0] = 8'(e);
        end
        if (e / 256 < 2) begin
          for (int i = 7; i > 0; i--) second_m[i] = second_m[i-1];
          second_m[0] = (e / 256 == 0) ? t : 8'(e);
        end
      end
      exp_sel = stage_select[3] ? second_m[stage_select[2:0]] : first_m[stage_select[2:0]];
      exp_oe = !output_enable_n;
      exp_bus = exp_oe ? exp_sel : 8'hzz;
    end
  end
  // compare where outputs have settled
  always @(negedge clk_sys) begin
    `CHK("y_bus", exp_bus, y_bus)
    `CHK("byte_output", exp_sel, byte_output)
    `CHK("byte_output_oe", exp_oe, byte_output_oe)
    `CHK("in_ready", 1'b1, in_ready)
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // mixed ops, chained runs, freeze-heavy, then a mid-run reset
  initial begin
    void'($urandom(32'h438fa228));
    rst = 1'b1;
    mode = 2'h0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      mode <= 2'(k % 3);
      if (k == 3) begin
        rst <= 1'b1;
        repeat (3) u_dbp_host.step();
        rst <= 1'b0;
      end
      for (int i = 0; i < 400; i++) u_dbp_host.step();
      $display("test %0d done, mismatches %0d", k, fail_count);
    end
    end_of_test();
  end
endmodule : test_dbp_pipe
